// ---- rtl/dmagc_pkg.sv ----
// Purpose: Shared constants and types of the DMA global control block
// Assumes: Byte addresses on a 32-bit Avalon-MM bus
// Notes:   Reserved register bits read as zero
package dmagc_pkg;

  // ***************************************
  // Register map
  // ***************************************
  localparam logic [31:0] OFF_GLOBAL_CONTROL      = 32'h1C00_4000;
  localparam logic [31:0] OFF_INTERRUPT_SUMMARY   = 32'h1C00_4004;
  localparam logic [31:0] OFF_DESCRIPTOR_BASE     = 32'h1C00_4008;
  localparam logic [31:0] OFF_CHANNEL_ENABLE_SET  = 32'h1C00_4020;
  localparam logic [31:0] OFF_CHANNEL_ENABLE_CLR  = 32'h1C00_4028;

  // ***************************************
  // Fields and reset values
  // ***************************************
  localparam int          NUM_CHANNELS            = 22;
  localparam int          MASTER_EN_BIT           = 0;
  localparam int          NORMAL_PEND_BIT         = 1;
  localparam int          ERROR_PEND_BIT          = 2;
  localparam int          BASE_LSB                = 9;
  localparam int          DESC_STRIDE_LOG2        = 4;
  localparam logic [31:0] RST_ZERO                = 32'h0000_0000;
  localparam logic [31:0] BASE_MASK               = 32'hFFFF_FE00;

  // ***************************************
  // Bus carrier
  // ***************************************
  typedef struct packed {
    logic        read;
    logic        write;
    logic [31:0] address;
    logic [31:0] writedata;
  } dmagc_req_s;

endpackage

// ---- rtl/dmagc_top.sv ----
// Purpose: Global control, summary status, descriptor base and channel enables of a DMA controller
// Assumes: Avalon-MM slave with waitrequest, one clock, asynchronous active-low reset
// Notes:   An access with clock enable high takes two cycles; waitrequest drops in the second
// How it works
// - Master enable bit 0 of control, reset 0, gates all channel activity.
// - Clearing master enable drops held triggers; new triggers accepted after re-enable.
// - Summary bit 1 shows any enabled normal interrupt pending.
// - Summary bit 2 shows any channel error interrupt pending.
// - Summary register is read-only; writes change nothing.
// - Descriptor base holds address bits 31:9, reset 0, low bits zero.
// - Descriptor of channel n sits at base plus n times sixteen.
// - Only implemented channels fetch descriptors; others are ignored.
// - Enable register holds one bit per channel in 21:0, reset 0.
// - Disabling a channel keeps its internal state intact.
// - Clearing then setting an enable pauses and resumes the channel.
// - Reading the enable register returns every channel's present enable.
// - Writing 1 to an enable bit sets that channel's enable.
// - Writing 0 to an enable bit leaves it unchanged.
// - Write-only clear register clears enables whose bits are written 1.
// - Any set channel error flag drives the shared interrupt output.
`timescale 1ns/1ns
`default_nettype none

module dmagc_top #(
  parameter int NCH = dmagc_pkg::NUM_CHANNELS
) (
  // Clock, reset, enable
  input  wire logic             clk_in,
  input  wire logic             rstn_in,
  input  wire logic             ce_in,
  // Avalon-MM slave
  input  wire logic             avs_read_in,
  input  wire logic             avs_write_in,
  input  wire logic [31:0]      avs_address_in,
  input  wire logic [31:0]      avs_writedata_in,
  output logic      [31:0]      avs_readdata_out,
  output logic                  avs_waitrequest_out,
  // Channel side
  input  wire logic [NCH-1:0]   trigger_in,
  input  wire logic [NCH-1:0]   normal_irq_flags_in,
  input  wire logic [NCH-1:0]   normal_irq_enable_in,
  input  wire logic [NCH-1:0]   channel_error_flags_in,
  output logic      [NCH-1:0]   trigger_pending_out,
  output logic      [NCH-1:0]   channel_run_out,
  // Descriptor fetch
  input  wire logic             fetch_req_in,
  input  wire logic [4:0]       fetch_chan_in,
  output logic                  fetch_valid_out,
  output logic      [31:0]      fetch_addr_out,
  // Shared interrupt
  output logic                  dma_irq_out
);

  // ***************************************
  // Helpers
  // ***************************************
  function automatic logic [31:0] desc_addr(input logic [31:0] base, input logic [4:0] ch);
    desc_addr = base + (32'(ch) << dmagc_pkg::DESC_STRIDE_LOG2);
  endfunction

  function automatic logic [31:0] widen(input logic [NCH-1:0] v);
    widen = 32'h0000_0000;
    widen[NCH-1:0] = v;
  endfunction

  // ***************************************
  // State
  // ***************************************
  dmagc_pkg::dmagc_req_s req;
  logic                  done_r;
  logic                  master_en_r;
  logic [31:0]           base_r;
  logic [NCH-1:0]        channel_enable_bits_r;
  logic [NCH-1:0]        trig_r;
  logic                  normal_irq_pending;
  logic                  error_irq_pending;
  logic                  wr_take;
  logic                  rd_take;
  logic [31:0]           rd_nxt;

  assign req.read      = avs_read_in;
  assign req.write     = avs_write_in;
  assign req.address   = avs_address_in;
  assign req.writedata = avs_writedata_in;

  assign normal_irq_pending = |(normal_irq_flags_in & normal_irq_enable_in);
  assign error_irq_pending  = |channel_error_flags_in;

  // ***************************************
  // Bus handshake
  // ***************************************
  // A frozen slave keeps the master waiting, so no write is acknowledged and lost
  assign avs_waitrequest_out = (req.read | req.write) & ~(done_r & ce_in);
  assign wr_take             = ce_in & req.write & done_r;
  assign rd_take             = ce_in & req.read & ~done_r;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      done_r <= 1'b0;
    end else if (ce_in) begin
      done_r <= (req.read | req.write) & ~done_r;
    end
  end

  // ***************************************
  // Read mux
  // ***************************************
  always_comb begin
    rd_nxt = dmagc_pkg::RST_ZERO;
    unique case (req.address)
      dmagc_pkg::OFF_GLOBAL_CONTROL: begin
        rd_nxt[dmagc_pkg::MASTER_EN_BIT] = master_en_r;
      end
      dmagc_pkg::OFF_INTERRUPT_SUMMARY: begin
        rd_nxt[dmagc_pkg::NORMAL_PEND_BIT] = normal_irq_pending;
        rd_nxt[dmagc_pkg::ERROR_PEND_BIT]  = error_irq_pending;
      end
      dmagc_pkg::OFF_DESCRIPTOR_BASE: begin
        rd_nxt = base_r;
      end
      dmagc_pkg::OFF_CHANNEL_ENABLE_SET: begin
        rd_nxt = widen(channel_enable_bits_r);
      end
      default: begin
        rd_nxt = dmagc_pkg::RST_ZERO;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      avs_readdata_out <= dmagc_pkg::RST_ZERO;
    end else if (rd_take) begin
      avs_readdata_out <= rd_nxt;
    end
  end

  // ***************************************
  // Control and base registers
  // ***************************************
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      master_en_r <= 1'b0;
    end else if (wr_take && req.address == dmagc_pkg::OFF_GLOBAL_CONTROL) begin
      master_en_r <= req.writedata[dmagc_pkg::MASTER_EN_BIT];
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      base_r <= dmagc_pkg::RST_ZERO;
    end else if (wr_take && req.address == dmagc_pkg::OFF_DESCRIPTOR_BASE) begin
      base_r <= req.writedata & dmagc_pkg::BASE_MASK;
    end
  end

  // ***************************************
  // Channel enables
  // ***************************************
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      channel_enable_bits_r <= '0;
    end else if (wr_take && req.address == dmagc_pkg::OFF_CHANNEL_ENABLE_SET) begin
      channel_enable_bits_r <= channel_enable_bits_r | req.writedata[NCH-1:0];
    end else if (wr_take && req.address == dmagc_pkg::OFF_CHANNEL_ENABLE_CLR) begin
      channel_enable_bits_r <= channel_enable_bits_r & ~req.writedata[NCH-1:0];
    end
  end

  // ***************************************
  // Triggers
  // ***************************************
  // Held triggers survive a channel disable; only master disable drops them
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      trig_r <= '0;
    end else if (ce_in) begin
      if (!master_en_r) begin
        trig_r <= '0;
      end else begin
        trig_r <= trig_r | trigger_in;
      end
    end
  end

  assign trigger_pending_out = trig_r;
  assign channel_run_out     = trig_r & channel_enable_bits_r & {NCH{master_en_r}};

  // ***************************************
  // Descriptor fetch
  // ***************************************
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      fetch_valid_out <= 1'b0;
      fetch_addr_out  <= dmagc_pkg::RST_ZERO;
    end else if (ce_in) begin
      fetch_valid_out <= fetch_req_in && master_en_r && (32'(fetch_chan_in) < NCH);
      fetch_addr_out  <= desc_addr(base_r, fetch_chan_in);
    end
  end

  // ***************************************
  // Shared interrupt
  // ***************************************
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dma_irq_out <= 1'b0;
    end else if (ce_in) begin
      dma_irq_out <= normal_irq_pending | error_irq_pending;
    end
  end

  // ***************************************
  // Assertions
  // ***************************************
  sequence s_write_to(logic [31:0] a);
    wr_take && req.address == a;
  endsequence

  property p_run_needs_master;
    @(posedge clk_in) disable iff (!rstn_in) !master_en_r |-> channel_run_out == '0;
  endproperty
  a_run_needs_master: assert property (p_run_needs_master) else $error("channel runs without master enable");

  property p_master_drop_clears;
    @(posedge clk_in) disable iff (!rstn_in) ce_in && !master_en_r |=> trig_r == '0;
  endproperty
  a_master_drop_clears: assert property (p_master_drop_clears) else $error("trigger kept while disabled");

  property p_trigger_taken;
    @(posedge clk_in) disable iff (!rstn_in) ce_in && master_en_r |=> (trig_r & $past(trigger_in)) == $past(trigger_in);
  endproperty
  a_trigger_taken: assert property (p_trigger_taken) else $error("trigger lost while enabled");

  property p_summary_read;
    @(posedge clk_in) disable iff (!rstn_in)
      rd_take && req.address == dmagc_pkg::OFF_INTERRUPT_SUMMARY
      |=> avs_readdata_out[2:1] == {$past(error_irq_pending), $past(normal_irq_pending)} && avs_readdata_out[0] == 1'b0;
  endproperty
  a_summary_read: assert property (p_summary_read) else $error("summary read wrong");

  property p_summary_ro;
    @(posedge clk_in) disable iff (!rstn_in)
      s_write_to(dmagc_pkg::OFF_INTERRUPT_SUMMARY) |=> $stable(master_en_r) && $stable(base_r) && $stable(channel_enable_bits_r);
  endproperty
  a_summary_ro: assert property (p_summary_ro) else $error("summary write changed state");

  property p_base_low_zero;
    @(posedge clk_in) disable iff (!rstn_in) base_r[8:0] == 9'h000;
  endproperty
  a_base_low_zero: assert property (p_base_low_zero) else $error("base low bits nonzero");

  property p_fetch_addr;
    @(posedge clk_in) disable iff (!rstn_in)
      ce_in && fetch_req_in && master_en_r && fetch_chan_in < 5'h16
      |=> fetch_valid_out && fetch_addr_out == $past(base_r) + {23'h000000, $past(fetch_chan_in), 4'h0};
  endproperty
  a_fetch_addr: assert property (p_fetch_addr) else $error("descriptor address wrong");

  property p_fetch_ignore;
    @(posedge clk_in) disable iff (!rstn_in) ce_in && fetch_chan_in >= 5'h16 |=> !fetch_valid_out;
  endproperty
  a_fetch_ignore: assert property (p_fetch_ignore) else $error("fetch beyond last channel");

  property p_enable_set;
    @(posedge clk_in) disable iff (!rstn_in)
      s_write_to(dmagc_pkg::OFF_CHANNEL_ENABLE_SET)
      |=> channel_enable_bits_r == ($past(channel_enable_bits_r) | $past(req.writedata[NCH-1:0]));
  endproperty
  a_enable_set: assert property (p_enable_set) else $error("enable set wrong");

  property p_enable_clr;
    @(posedge clk_in) disable iff (!rstn_in)
      s_write_to(dmagc_pkg::OFF_CHANNEL_ENABLE_CLR)
      |=> channel_enable_bits_r == ($past(channel_enable_bits_r) & ~$past(req.writedata[NCH-1:0]));
  endproperty
  a_enable_clr: assert property (p_enable_clr) else $error("enable clear wrong");

  property p_enable_hold;
    @(posedge clk_in) disable iff (!rstn_in)
      !wr_take ##1 1'b1 |-> $stable(channel_enable_bits_r);
  endproperty
  a_enable_hold: assert property (p_enable_hold) else $error("enable changed without write");

  property p_irq;
    @(posedge clk_in) disable iff (!rstn_in)
      ce_in && (error_irq_pending || normal_irq_pending) |=> dma_irq_out;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_access_time;
    @(posedge clk_in) disable iff (!rstn_in)
      ce_in && (req.read || req.write) && !done_r ##1 ce_in |-> !avs_waitrequest_out;
  endproperty
  a_access_time: assert property (p_access_time) else $error("waitrequest held too long");

  property p_freeze_wait;
    @(posedge clk_in) disable iff (!rstn_in)
      !ce_in && (req.read || req.write) |-> avs_waitrequest_out;
  endproperty
  a_freeze_wait: assert property (p_freeze_wait) else $error("bus answered while frozen");

  property p_enable_read;
    @(posedge clk_in) disable iff (!rstn_in)
      rd_take && req.address == dmagc_pkg::OFF_CHANNEL_ENABLE_SET
      |=> avs_readdata_out[NCH-1:0] == $past(channel_enable_bits_r);
  endproperty
  a_enable_read: assert property (p_enable_read) else $error("enable read wrong");

  property p_irq_low;
    @(posedge clk_in) disable iff (!rstn_in)
      ce_in && !error_irq_pending && !normal_irq_pending |=> !dma_irq_out;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("interrupt raised without cause");

  property p_freeze;
    @(posedge clk_in) disable iff (!rstn_in)
      !ce_in |=> $stable(master_en_r) && $stable(trig_r) && $stable(channel_enable_bits_r)
                 && $stable(done_r) && $stable(dma_irq_out) && $stable(fetch_valid_out);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");

  property p_disable_keeps;
    @(posedge clk_in) disable iff (!rstn_in)
      s_write_to(dmagc_pkg::OFF_CHANNEL_ENABLE_CLR) && master_en_r
      |=> (trig_r & $past(trig_r)) == $past(trig_r);
  endproperty
  a_disable_keeps: assert property (p_disable_keeps) else $error("channel disable lost held trigger");

  property p_base_write;
    @(posedge clk_in) disable iff (!rstn_in)
      s_write_to(dmagc_pkg::OFF_DESCRIPTOR_BASE) |=> base_r[31:9] == $past(req.writedata[31:9]);
  endproperty
  a_base_write: assert property (p_base_write) else $error("base write not taken");

  property p_master_write;
    @(posedge clk_in) disable iff (!rstn_in)
      s_write_to(dmagc_pkg::OFF_GLOBAL_CONTROL) |=> master_en_r == $past(req.writedata[dmagc_pkg::MASTER_EN_BIT]);
  endproperty
  a_master_write: assert property (p_master_write) else $error("master enable write not taken");

endmodule

`default_nettype wire

// ---- test/dmagc_bus_model.sv ----
// Purpose: Avalon-MM master standing in for processor software
// Assumes: Called from a process that owns the bus; one transfer at a time
// Notes:   Idle address and data lines carry inverted values, not the last ones
`timescale 1ns/1ns
`default_nettype none
module dmagc_bus_model (
  // Clock
  input  wire logic                  clk_in,
  // Slave answer
  input  wire logic                  waitrequest_in,
  input  wire logic [31:0]           readdata_in,
  // Request carrier
  output var  dmagc_pkg::dmagc_req_s req_out
);
  initial req_out = '0;

  // Raise after an edge, hold until waitrequest is sampled low, then release
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_in);
    req_out <= '{read: !w, write: w, address: a, writedata: d};
    do @(posedge clk_in); while (waitrequest_in !== 1'h0);
    q = readdata_in;
    req_out <= '{read: 1'h0, write: 1'h0, address: ~a, writedata: ~d};
  endtask
endmodule
`default_nettype wire

// ---- test/test_dmagc_top.sv ----
// Purpose: Self-checking bench of the DMA global control block
// Assumes: Clock enable low only in the freeze scenario
// Notes:   Only mismatches and the verdict are printed
`timescale 1ns/1ns
`default_nettype none
module test_dmagc_top;
  localparam logic [31:0] A_CTL = dmagc_pkg::OFF_GLOBAL_CONTROL;
  localparam logic [31:0] A_SUM = dmagc_pkg::OFF_INTERRUPT_SUMMARY;
  localparam logic [31:0] A_BAS = dmagc_pkg::OFF_DESCRIPTOR_BASE;
  localparam logic [31:0] A_SET = dmagc_pkg::OFF_CHANNEL_ENABLE_SET;
  localparam logic [31:0] A_CLR = dmagc_pkg::OFF_CHANNEL_ENABLE_CLR;
  logic                  clk_in = 1'h0;
  logic                  rstn_in = 1'h0;
  logic                  ce = 1'h1;
  logic [21:0]           trig = '0;
  logic [21:0]           nflag = '0;
  logic [21:0]           nen = '0;
  logic [21:0]           eflag = '0;
  logic                  freq = 1'h0;
  logic [4:0]            fchan = 5'h00;
  logic [31:0]           rdata, faddr;
  logic                  waitreq, fvalid, irq;
  logic [21:0]           pend, run;
  dmagc_pkg::dmagc_req_s bus_req;
  int                    num_errors = 0;
  int                    tests_run = 0;

  always #10 clk_in = ~clk_in;

  dmagc_top u_dmagc_top (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce),
    .avs_read_in(bus_req.read), .avs_write_in(bus_req.write), .avs_address_in(bus_req.address),
    .avs_writedata_in(bus_req.writedata), .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
    .trigger_in(trig), .normal_irq_flags_in(nflag), .normal_irq_enable_in(nen),
    .channel_error_flags_in(eflag), .trigger_pending_out(pend), .channel_run_out(run),
    .fetch_req_in(freq), .fetch_chan_in(fchan), .fetch_valid_out(fvalid), .fetch_addr_out(faddr),
    .dma_irq_out(irq));

  dmagc_bus_model u_dmagc_bus_model (.clk_in(clk_in), .waitrequest_in(waitreq), .readdata_in(rdata),
    .req_out(bus_req));

  // ***************************************
  // Shared tasks
  // ***************************************
  task automatic give_verdict;
    if (num_errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    u_dmagc_bus_model.xfer(1'h1, a, d, q);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] q;
    u_dmagc_bus_model.xfer(1'h0, a, 32'h0000_0000, q);
    chk(q, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic fetch(input logic [4:0] ch, input logic v, input logic [31:0] exp);
    logic        seen;
    logic [31:0] a;
    seen = 1'h0;
    a = 32'h0000_0000;
    @(posedge clk_in);
    freq <= 1'h1;
    fchan <= ch;
    @(posedge clk_in);
    freq <= 1'h0;
    repeat (3) begin
      #1;
      if (fvalid === 1'h1) begin
        seen = 1'h1;
        a = faddr;
      end
      @(posedge clk_in);
    end
    chk(32'(seen), 32'(v));
    if (v) chk(a, exp);
  endtask

  // ***************************************
  // Scenarios
  // ***************************************
  task automatic t_reset;
    rd(A_CTL, 32'h0000_0000);
    rd(A_SUM, 32'h0000_0000);
    rd(A_BAS, 32'h0000_0000);
    rd(A_SET, 32'h0000_0000);
    rd(32'h1C00_4010, 32'h0000_0000);
  endtask
  task automatic t_enable;
    wr(A_SET, 32'h0000_0001);
    wr(A_SET, 32'h0020_0000);
    rd(A_SET, 32'h0020_0001);
    wr(A_CLR, 32'h0000_0001);
    rd(A_SET, 32'h0020_0000);
    wr(A_SET, 32'h003F_FFFF);
    rd(A_SET, 32'h003F_FFFF);
    wr(A_CLR, 32'h003F_FFFF);
    rd(A_SET, 32'h0000_0000);
  endtask
  task automatic t_trigger;
    wr(A_BAS, 32'h0000_0200);
    wr(A_SET, 32'h0000_0008);
    @(posedge clk_in);
    trig <= 22'h000008;
    tick(2);
    chk(32'(pend), 32'h0000_0000);
    wr(A_CTL, 32'h0000_0001);
    tick(1);
    chk(32'(run), 32'h0000_0008);
    @(posedge clk_in);
    trig <= 22'h000000;
    wr(A_CLR, 32'h0000_0008);
    tick(1);
    chk(32'(run), 32'h0000_0000);
    chk(32'(pend), 32'h0000_0008);
    wr(A_SET, 32'h0000_0008);
    tick(1);
    chk(32'(run), 32'h0000_0008);
    wr(A_CTL, 32'h0000_0000);
    tick(1);
    chk(32'(pend), 32'h0000_0000);
    wr(A_CTL, 32'h0000_0001);
    @(posedge clk_in);
    trig <= 22'h000008;
    @(posedge clk_in);
    trig <= 22'h000000;
    #1;
    chk(32'(pend), 32'h0000_0008);
    rd(A_CTL, 32'h0000_0001);
  endtask
  task automatic t_irq;
    @(posedge clk_in);
    eflag <= 22'h000020;
    tick(2);
    chk(32'(irq), 32'h0000_0001);
    rd(A_SUM, 32'h0000_0004);
    wr(A_SUM, 32'h0000_0000);
    rd(A_SUM, 32'h0000_0004);
    @(posedge clk_in);
    eflag <= 22'h000000;
    nflag <= 22'h000010;
    tick(2);
    chk(32'(irq), 32'h0000_0000);
    rd(A_SUM, 32'h0000_0000);
    @(posedge clk_in);
    nen <= 22'h000010;
    tick(2);
    chk(32'(irq), 32'h0000_0001);
    rd(A_SUM, 32'h0000_0002);
  endtask
  task automatic t_freeze;
    @(posedge clk_in);
    ce <= 1'h0;
    nflag <= 22'h000000;
    trig <= 22'h000010;
    tick(2);
    chk(32'(irq), 32'h0000_0001);
    chk(32'(pend), 32'h0000_0008);
    @(posedge clk_in);
    ce <= 1'h1;
    trig <= 22'h000000;
    tick(2);
    chk(32'(irq), 32'h0000_0000);
    chk(32'(pend), 32'h0000_0008);
  endtask
  task automatic t_fetch;
    wr(A_BAS, 32'hFFFF_FE00);
    rd(A_BAS, 32'hFFFF_FE00);
    fetch(5'h00, 1'h1, 32'hFFFF_FE00);
    fetch(5'h01, 1'h1, 32'hFFFF_FE10);
    fetch(5'h15, 1'h1, 32'hFFFF_FF50);
    fetch(5'h16, 1'h0, 32'h0000_0000);
    fetch(5'h1F, 1'h0, 32'h0000_0000);
    wr(A_CTL, 32'h0000_0000);
    fetch(5'h05, 1'h0, 32'h0000_0000);
  endtask

  initial begin
    repeat (4) @(posedge clk_in);
    rstn_in <= 1'h1;
    t_reset;
    t_enable;
    t_trigger;
    t_irq;
    t_freeze;
    t_fetch;
    give_verdict;
  end
  initial begin
    repeat (3000) @(posedge clk_in);
    num_errors++;
    give_verdict;
  end
endmodule
`default_nettype wire
